/* File: inc/itt_defs.svh */
/*
 constants for the interval / time-base timer: register offsets, field positions, reset values.
 assumes inclusion by bare name from the package and the design file.
*/
`ifndef ITT_DEFS_SVH
`define ITT_DEFS_SVH

`define ITT_OFF_MODE 8'h00
`define ITT_OFF_COUNT 8'h04
`define ITT_OFF_STATUS 8'h08
`define ITT_OFF_CLEAR 8'h0C
`define ITT_OFF_ENABLE 8'h10
`define ITT_OFF_OUTEN 8'h14

`define ITT_MODE_RESET 8'h10
`define ITT_MODE_RSVD_BIT 4
`define ITT_OCS_HI 7
`define ITT_OCS_LO 5
`define ITT_CCS_HI 3
`define ITT_CCS_LO 0
`define ITT_CCS_TB_BIT 3
`define ITT_CCS_HOLD_BIT 2

`define ITT_COUNT_RESET 8'h00
`define ITT_COUNT_MAX 8'hFF
`define ITT_STAT_OVF_BIT 0

`define ITT_SYS_PRESC_W 13
`define ITT_WATCH_PRESC_W 15
`define ITT_WATCH_TB_TAP 7

`endif

/* File: inc/itt_pkg.sv */
/*
 types for the interval / time-base timer.
 assumes itt_defs.svh is on the include path.
*/
`include "itt_defs.svh"
package itt_pkg;
   typedef enum logic [1:0] {
      ITT_BUS_IDLE = 2'b00,
      ITT_BUS_RESP = 2'b01
   } itt_bus_st_t;

   typedef struct packed {
      logic [7:0] mode;
      logic [7:0] count;
      logic [12:0] sys_presc;
      logic [14:0] watch_presc;
      logic watch_sync1;
      logic watch_sync2;
      logic watch_prev;
      logic ovf_status;
      logic ovf_enable;
      logic clk_out_en;
      logic clk_out;
      logic irq;
      itt_bus_st_t wst;
      itt_bus_st_t rst;
      logic aw_got;
      logic w_got;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic [1:0] bresp;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } itt_state_t;

   typedef struct packed {
      logic awvalid;
      logic [7:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [7:0] araddr;
      logic rready;
   } itt_axi_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } itt_axi_rsp_t;
endpackage

/* File: hdl/itt_timer.sv */
/*
 interval / time-base timer with divided clock output and AXI4-Lite register slave.
 assumes watch_clk_in is a slow level (32.768 kHz) sampled on clk, and that the host
 follows AXI4-Lite handshaking with one write and one read outstanding.
*/
// Register access over AXI4-Lite and the address map were chosen for this implementation.
// Behaviour
// - eight-bit counter, interval or time-base use
// - interval clocks: system divided 8192 down to 8
// - time-base periods: 1, 0.5, 0.25, 0.03125 s
// - time base counts only on watch clock rising edges
// - counter overflow raises an interrupt request
// - clock pin: watch or system divided 32..4
// - clock pin is output only
// - overflow from FF sets flag, wraps, continues
// - four-bit counter clock select field decoding
// - time-base hold bit clears counter and watch prescaler
// - three-bit output select field decoding
`timescale 1ns/10ps
`include "itt_defs.svh"
module itt_timer (
   input wire logic clk,
   input wire logic reset,
   input wire logic watch_clk_in,
   input wire itt_pkg::itt_axi_req_t axi_req,
   output itt_pkg::itt_axi_rsp_t axi_rsp,
   output logic divided_clock_out_pin,
   output logic irq
);
   import itt_pkg::*;

   itt_state_t s_reg;
   itt_state_t s_next;

   // interval tap index into the system prescaler for each code
   function automatic logic [3:0] sys_tap(input logic [2:0] sel);
      case (sel)
         3'h0: sys_tap = 4'hC;
         3'h1: sys_tap = 4'hB;
         3'h2: sys_tap = 4'hA;
         3'h3: sys_tap = 4'h8;
         3'h4: sys_tap = 4'h7;
         3'h5: sys_tap = 4'h6;
         3'h6: sys_tap = 4'h4;
         default: sys_tap = 4'h2;
      endcase
   endfunction

   // register address decode shared by read and write paths
   function automatic logic [2:0] reg_sel(input logic [7:0] a);
      case (a)
         `ITT_OFF_MODE: reg_sel = 3'h0;
         `ITT_OFF_COUNT: reg_sel = 3'h1;
         `ITT_OFF_STATUS: reg_sel = 3'h2;
         `ITT_OFF_CLEAR: reg_sel = 3'h3;
         `ITT_OFF_ENABLE: reg_sel = 3'h4;
         `ITT_OFF_OUTEN: reg_sel = 3'h5;
         default: reg_sel = 3'h7;
      endcase
   endfunction

   logic watch_rise;
   logic [12:0] sys_inc;
   logic [14:0] watch_inc;
   logic sys_tick;
   logic watch_tick;
   logic cnt_tick;
   logic tb_mode;
   logic tb_hold;
   logic overflow;
   logic [3:0] tap;
   logic [3:0] wtap;
   logic out_level;
   logic do_write;
   logic do_read;
   logic [2:0] wsel;
   logic [7:0] wbyte;

   always_comb begin
      s_next = s_reg;
      tb_mode = s_reg.mode[`ITT_CCS_TB_BIT];
      tb_hold = tb_mode & s_reg.mode[`ITT_CCS_HOLD_BIT];
      // watch clock edges counted only when present
      watch_rise = s_reg.watch_sync2 & ~s_reg.watch_prev;
      sys_inc = s_reg.sys_presc + 13'h0001;
      watch_inc = s_reg.watch_presc + 15'h0001;
      tap = sys_tap(s_reg.mode[2:0]);
      // bit k of a free-running prescaler rising means divide by 2^(k+1)
      sys_tick = sys_inc[tap] & ~s_reg.sys_presc[tap];
      // ticks every 128, 64, 32 or 4 watch edges: 256 ticks give 1, 0.5, 0.25, 0.03125 s
      case (s_reg.mode[1:0])
         2'h0: wtap = 4'h6;
         2'h1: wtap = 4'h5;
         2'h2: wtap = 4'h4;
         default: wtap = 4'h1;
      endcase
      watch_tick = watch_rise & watch_inc[wtap] & ~s_reg.watch_presc[wtap];
      cnt_tick = tb_mode ? watch_tick : sys_tick;
      overflow = cnt_tick & ~tb_hold & (s_reg.count == `ITT_COUNT_MAX);

      s_next.sys_presc = sys_inc;
      s_next.watch_sync1 = watch_clk_in;
      s_next.watch_sync2 = s_reg.watch_sync1;
      s_next.watch_prev = s_reg.watch_sync2;
      if (watch_rise) begin
         s_next.watch_presc = watch_inc;
      end
      if (tb_hold) begin
         s_next.count = `ITT_COUNT_RESET;
         s_next.watch_presc = 15'h0000;
      end else if (cnt_tick) begin
         s_next.count = s_reg.count + 8'h01; // wraps FF to 00
      end

      // output select: codes 0..3 system /32../4, 4..7 watch /32../4
      case (s_reg.mode[`ITT_OCS_HI:`ITT_OCS_LO])
         3'h0: out_level = s_reg.sys_presc[4];
         3'h1: out_level = s_reg.sys_presc[3];
         3'h2: out_level = s_reg.sys_presc[2];
         3'h3: out_level = s_reg.sys_presc[1];
         3'h4: out_level = s_reg.watch_presc[4];
         3'h5: out_level = s_reg.watch_presc[3];
         3'h6: out_level = s_reg.watch_presc[2];
         default: out_level = s_reg.watch_presc[1];
      endcase
      s_next.clk_out = s_reg.clk_out_en & out_level;

      // AXI4-Lite write: address and data in either order
      if (s_reg.wst == ITT_BUS_IDLE) begin
         if (axi_req.awvalid & ~s_reg.aw_got) begin
            s_next.aw_got = 1'b1;
            s_next.awaddr = axi_req.awaddr;
         end
         if (axi_req.wvalid & ~s_reg.w_got) begin
            s_next.w_got = 1'b1;
            s_next.wdata = axi_req.wdata;
            s_next.wstrb = axi_req.wstrb;
         end
      end
      do_write = (s_reg.wst == ITT_BUS_IDLE) & s_reg.aw_got & s_reg.w_got;
      wsel = reg_sel(s_reg.awaddr);
      wbyte = s_reg.wdata[7:0];
      if (do_write) begin
         s_next.wst = ITT_BUS_RESP;
         s_next.aw_got = 1'b0;
         s_next.w_got = 1'b0;
         s_next.bresp = (wsel == 3'h7) ? 2'b10 : 2'b00;
         if (s_reg.wstrb[0]) begin
            case (wsel)
               3'h0: s_next.mode = {wbyte[7:5], 1'b1, wbyte[3:0]};
               3'h3: if (wbyte[`ITT_STAT_OVF_BIT]) s_next.ovf_status = 1'b0;
               3'h4: s_next.ovf_enable = wbyte[`ITT_STAT_OVF_BIT];
               3'h5: s_next.clk_out_en = wbyte[0];
               default: ;
            endcase
         end
      end
      if (s_reg.wst == ITT_BUS_RESP && axi_req.bready) begin
         s_next.wst = ITT_BUS_IDLE;
      end
      // overflow sets the flag, winning over a clear in the same cycle
      if (overflow) begin
         s_next.ovf_status = 1'b1;
      end
      s_next.irq = s_next.ovf_status & s_next.ovf_enable;

      // AXI4-Lite read
      do_read = (s_reg.rst == ITT_BUS_IDLE) & axi_req.arvalid;
      if (do_read) begin
         s_next.rst = ITT_BUS_RESP;
         s_next.rresp = 2'b00;
         case (reg_sel(axi_req.araddr))
            3'h0: s_next.rdata = {24'h000000, s_reg.mode};
            3'h1: s_next.rdata = {24'h000000, s_reg.count};
            3'h2: s_next.rdata = {31'h00000000, s_reg.ovf_status};
            3'h3: s_next.rdata = 32'h00000000;
            3'h4: s_next.rdata = {31'h00000000, s_reg.ovf_enable};
            3'h5: s_next.rdata = {31'h00000000, s_reg.clk_out_en};
            default: begin
               s_next.rdata = 32'h00000000;
               s_next.rresp = 2'b10;
            end
         endcase
      end
      if (s_reg.rst == ITT_BUS_RESP && axi_req.rready) begin
         s_next.rst = ITT_BUS_IDLE;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s_reg <= '0;
         s_reg.mode <= `ITT_MODE_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   always_comb begin
      axi_rsp.awready = (s_reg.wst == ITT_BUS_IDLE) & ~s_reg.aw_got;
      axi_rsp.wready = (s_reg.wst == ITT_BUS_IDLE) & ~s_reg.w_got;
      axi_rsp.bvalid = (s_reg.wst == ITT_BUS_RESP);
      axi_rsp.bresp = s_reg.bresp;
      axi_rsp.arready = (s_reg.rst == ITT_BUS_IDLE);
      axi_rsp.rvalid = (s_reg.rst == ITT_BUS_RESP);
      axi_rsp.rdata = s_reg.rdata;
      axi_rsp.rresp = s_reg.rresp;
   end

   assign divided_clock_out_pin = s_reg.clk_out;
   assign irq = s_reg.irq;
endmodule

/* File: dv/itt_checker.sv */
/* port checker for itt_timer, bound below; one clock, async reset */
`timescale 1ns/10ps
module itt_checker (
   input wire logic clk,
   input wire logic reset,
   input wire itt_pkg::itt_axi_req_t axi_req,
   input wire itt_pkg::itt_axi_rsp_t axi_rsp,
   input wire logic irq
);
   import itt_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   wr_ans_a: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
      |-> ##[1:2] axi_rsp.bvalid) else $error("write late");
   rd_ans_a: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid) else $error("read late");
   b_hold_a: assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
      else $error("write answer dropped");
   r_hold_a: assert property (axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
      else $error("read answer dropped");
   ar_busy_a: assert property (axi_rsp.rvalid |-> !axi_rsp.arready) else $error("read busy");
   w_busy_a: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready) else $error("write busy");
   bad_addr_a: assert property (axi_req.arvalid && axi_rsp.arready && axi_req.araddr > 8'h14 |=> axi_rsp.rresp == 2'h2)
      else $error("unmapped read");
   byte_wide_a: assert property (axi_rsp.rvalid |-> axi_rsp.rdata[31:8] == 24'h0) else $error("upper bits");
   cover property (axi_rsp.bvalid && axi_req.bready);
   cover property (axi_rsp.rvalid && axi_rsp.rresp == 2'h2);
   cover property ($rose(irq));
endmodule
bind itt_timer itt_checker chk (.clk(clk), .reset(reset), .axi_req(axi_req), .axi_rsp(axi_rsp), .irq(irq));

/* File: dv/itt_timer_tb.sv */
/* self-checking bench for itt_timer; drives bus, watch clock and reset itself */
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
   $display("Error %s exp %h got %h", n, e, g); end end
module itt_timer_tb;
   import itt_pkg::*;
   logic clk = 1'h0, reset = 1'h1, watch = 1'h0, pin, irq;
   itt_axi_req_t req = '0;
   itt_axi_rsp_t rsp, rs;
   int num_errors = 0, n_compared = 0, cyc = 0, t0, t1;
   itt_timer dut (.clk(clk), .reset(reset), .watch_clk_in(watch), .axi_req(req), .axi_rsp(rsp),
      .divided_clock_out_pin(pin), .irq(irq));
   initial forever #12.5 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   always @(posedge clk) if (cyc % 610 == 609) watch <= ~watch;
   task automatic summarize;
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic hang(input int i);
      `CHK("wait", 1'h1, i < 20000)
      if (i >= 20000) summarize();
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      int i;
      logic aw_ok, w_ok, b_ok;
      @(posedge clk);
      req <= '{awvalid: 1'h1, awaddr: a, wvalid: 1'h1, wdata: v, wstrb: 4'hF, bready: 1'h1, default: '0};
      for (i = 0; i < 20000; i++) begin
         #1;
         // readies sampled settled, acted on at the edge that takes them
         aw_ok = rsp.awready;
         w_ok = rsp.wready;
         b_ok = (rsp.bvalid === 1'h1);
         @(posedge clk);
         if (aw_ok) req.awvalid <= 1'h0;
         if (w_ok) req.wvalid <= 1'h0;
         if (b_ok) break;
      end
      req.bready <= 1'h0;
      hang(i);
   endtask
   task automatic rd(input logic [7:0] a);
      int i;
      logic ar_ok, r_ok;
      itt_axi_rsp_t cap;
      @(posedge clk);
      req <= '{arvalid: 1'h1, araddr: a, rready: 1'h1, default: '0};
      for (i = 0; i < 20000; i++) begin
         #1;
         ar_ok = rsp.arready;
         r_ok = (rsp.rvalid === 1'h1);
         cap = rsp;
         @(posedge clk);
         if (ar_ok) req.arvalid <= 1'h0;
         if (r_ok) break;
      end
      rs = cap;
      req.rready <= 1'h0;
      hang(i);
   endtask
   task automatic wirq(output int t);
      int i;
      for (i = 0; i < 20000 && irq !== 1'h1; i++) begin
         @(posedge clk);
         #1;
      end
      t = cyc;
      hang(i);
   endtask
   task automatic prise(output int t);
      int i, j;
      for (i = 0; i < 20000 && pin !== 1'h0; i++) begin
         @(posedge clk);
         #1;
      end
      for (j = 0; j < 20000 && pin !== 1'h1; j++) begin
         @(posedge clk);
         #1;
      end
      t = cyc;
      hang(i > j ? i : j);
   endtask
   task automatic t_regs;
      rd(8'h00);
      `CHK("mode", 32'h10, rs.rdata)
      wr(8'h00, 32'h07);
      rd(8'h00);
      `CHK("mode", 32'h17, rs.rdata)
      rd(8'h20);
      `CHK("resp", 2'h2, rs.rresp)
   endtask
   task automatic t_ovf;
      int dv [2] = '{8, 32};
      wr(8'h0C, 32'h1);
      wr(8'h10, 32'h1);
      foreach (dv[k]) begin
         wr(8'h00, 32'h7 - k);
         wirq(t0);
         wr(8'h0C, 32'h1);
         repeat (2) @(posedge clk);
         `CHK("irq", 1'h0, irq)
         wirq(t1);
         `CHK("period", 256 * dv[k], t1 - t0)
         wr(8'h0C, 32'h1);
      end
      wr(8'h10, 32'h0);
      wr(8'h00, 32'h07);
      repeat (2100) @(posedge clk);
      `CHK("masked irq", 1'h0, irq)
      rd(8'h08);
      `CHK("status", 32'h1, rs.rdata)
      wr(8'h0C, 32'h1);
   endtask
   task automatic t_hold;
      wr(8'h00, 32'h0C);
      rd(8'h04);
      `CHK("held count", 32'h0, rs.rdata)
      // shortest period: one tick per 4 watch edges, 12 watch periods give 3 ticks
      wr(8'h00, 32'h0B);
      repeat (14640) @(posedge clk);
      rd(8'h04);
      `CHK("time base count", 32'h3, rs.rdata)
   endtask
   task automatic t_clk;
      wr(8'h14, 32'h1);
      for (int c = 0; c < 5; c++) begin
         wr(8'h00, 32'((c < 4 ? c : 7) << 5));
         prise(t0);
         prise(t1);
         `CHK("pin period", c < 4 ? 32 >> c : 4880, t1 - t0)
      end
   endtask
   initial begin
      repeat (2) @(posedge clk);
      reset <= 1'h0;
      t_regs();
      t_ovf();
      t_hold();
      t_clk();
      summarize();
   end
endmodule
